// [bench/cdcd_host_model.sv]
`timescale 1ns/10ps
module cdcd_host_model
  import cdcd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  logic bus8;
  logic [23:0] page;

  initial begin
    page = 24'h000000;
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
    bus8 = RST_BUS8;
  end

  // Single word transfer; entered just after a rising edge
  task automatic xfer(input logic [7:0] ofs, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
    hsel_o <= 1'b1;
    haddr_o <= {page, ofs};
    htrans_o <= 2'h2;
    hwrite_o <= wr;
    hsize_o <= 3'h2;
    @(posedge sys_clk_i);
    while (hready_i !== 1'b1) @(posedge sys_clk_i);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= {page, wd};
    @(posedge sys_clk_i);
    while (hready_i !== 1'b1) @(posedge sys_clk_i);
    rd = hrdata_i[7:0];
    // Released data lines must not keep the old byte
    hwdata_o <= ~{page, wd};
    // Upper address bits walk; the register window mirrors
    page = page + 24'h010101;
  endtask

  task automatic put(input logic [7:0] ofs, input logic [7:0] b);
    logic [7:0] rd;
    if (bus8) begin
      xfer(ofs, 1'b1, b, rd);
    end else begin
      xfer(ofs, 1'b1, {b[7:4], 4'h0}, rd);
      xfer(ofs, 1'b1, {b[3:0], 4'h0}, rd);
    end
  endtask

  task automatic wait_ready();
    logic [7:0] st;
    st = 8'h80;
    while (st[7] !== 1'b0) xfer(OFS_INSTR, 1'b0, 8'h00, st);
  endtask

  task automatic instr(input logic [7:0] b);
    put(OFS_INSTR, b);
    // Parallel link only; serial width rule moot
    if (b[7:5] == 3'b001) bus8 = b[4];
    wait_ready();
  endtask

  task automatic data_wr(input logic [7:0] b);
    put(OFS_DATA, b);
    wait_ready();
  endtask

  task automatic data_rd(input logic [7:0] addr_cmd, output logic [7:0] b);
    instr(addr_cmd);
    xfer(OFS_DATA, 1'b0, 8'h00, b);
    wait_ready();
  endtask
endmodule

// [bench/test_char_display_command_decoder.sv]
`timescale 1ns/10ps
module test_char_display_command_decoder
  import cdcd_pkg::*;
;
  localparam int LIMIT = 20000;
  localparam int PERIOD_NS = 50;
  time t0;
  logic sys_clk, arst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, brightness;
  logic [2:0] hsize;
  logic display_on, power_enable, cursor_on, cursor_all_dots, glyph_select, busy;
  logic [5:0] display_shift;
  logic [6:0] cursor_addr;
  logic [7:0] r;
  int fail_count, n_tests, cycles, n;

  cdcd_top #(.BLINK_HALF(8)) u_dut (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata), .display_on_o(display_on),
    .power_enable_o(power_enable), .cursor_on_o(cursor_on), .cursor_all_dots_o(cursor_all_dots),
    .brightness_o(brightness), .display_shift_o(display_shift), .cursor_addr_o(cursor_addr),
    .glyph_select_o(glyph_select), .busy_o(busy));

  cdcd_host_model u_host (.sys_clk_i(sys_clk), .hready_i(hreadyout), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

  always #25 sys_clk = ~sys_clk;

  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask

  task automatic t_entry();
    u_host.instr(8'h85);
    u_host.instr(8'h06);
    u_host.data_wr(8'hA5);
    chk(32'(cursor_addr), 32'h06, "inc step");
    u_host.instr(8'h04);
    u_host.data_wr(8'h3C);
    chk(32'(cursor_addr), 32'h05, "dec step");
    u_host.instr(8'h05);
    u_host.data_rd(8'h86, r);
    chk(32'(r), 32'h3C, "read byte");
    chk(32'({display_shift, cursor_addr}), 32'h05, "read no pan");
  endtask

  task automatic t_pan();
    u_host.instr(8'h07);
    u_host.instr(8'h80);
    u_host.data_wr(8'h20);
    chk(32'({display_shift, cursor_addr}), {19'h0, 6'h01, 7'h01}, "pan left");
    u_host.instr(8'h05);
    u_host.data_wr(8'h21);
    chk(32'({display_shift, cursor_addr}), 32'h0, "pan right");
    u_host.data_wr(8'h22);
    chk(32'(display_shift), 32'h27, "pan wrap");
    u_host.instr(8'h07);
    u_host.data_wr(8'h23);
    chk(32'(display_shift), 32'h00, "pan back");
  endtask

  task automatic t_display();
    for (int c = 8; c < 16; c++) begin
      u_host.instr(8'(c));
      chk(32'({display_on, power_enable, cursor_on}), 32'({c[2], c[2], c[1]}), "display ctl");
    end
    n = 0;
    repeat (64) begin
      @(posedge sys_clk);
      if (cursor_all_dots === 1'b1) n++;
    end
    chk(32'(n >= 30 && n <= 34), 32'h1, "blink duty");
    u_host.instr(8'h0B);
    n = 0;
    repeat (32) begin
      @(posedge sys_clk);
      if (cursor_all_dots !== 1'b0) n++;
    end
    chk(32'(n), 32'h0, "blink dark");
  endtask

  task automatic t_shift();
    u_host.instr(8'h06);
    u_host.instr(8'h83);
    u_host.data_wr(8'h5A);
    u_host.instr(8'h83);
    u_host.instr(8'h10);
    chk(32'(cursor_addr), 32'h02, "cursor left");
    u_host.instr(8'h17);
    chk(32'(cursor_addr), 32'h03, "cursor right");
    u_host.instr(8'h1A);
    chk(32'({display_shift, cursor_addr}), {19'h0, 6'h01, 7'h03}, "shift left");
    u_host.instr(8'h1D);
    chk(32'({display_shift, cursor_addr}), 32'h03, "shift right");
    u_host.data_rd(8'h83, r);
    chk(32'(r), 32'h5A, "ram kept");
  endtask

  task automatic t_bright();
    for (int b = 0; b < 4; b++) begin
      u_host.instr(8'h3F);
      u_host.data_wr(8'hFC | 8'(b));
      chk(32'(brightness), 32'(b), "brightness");
    end
    u_host.instr(8'h30);
    u_host.instr(8'h0C);
    u_host.data_wr(8'h01);
    chk(32'(brightness), 32'h3, "disarmed");
    u_host.instr(8'h20);
    u_host.instr(8'h0E);
    chk(32'({display_on, cursor_on}), 32'h3, "nibble instr");
    u_host.xfer(OFS_STATE, 1'b0, 8'h00, r);
    chk(32'(r[5]), 32'h0, "bus4");
    u_host.instr(8'h30);
    u_host.data_wr(8'h02);
    u_host.xfer(OFS_STATE, 1'b0, 8'h00, r);
    chk(32'({r[5], brightness}), 32'h6, "bus8 back");
  endtask

  task automatic t_glyph();
    u_host.instr(8'h07);
    u_host.instr(8'h7F);
    chk(32'({glyph_select, cursor_addr}), 32'hBF, "glyph addr");
    u_host.data_wr(8'hFF);
    chk(32'({display_shift, cursor_addr}), 32'h0, "glyph wrap");
    u_host.xfer(OFS_INSTR, 1'b0, 8'h00, r);
    chk(32'(r), 32'h00, "status");
    u_host.data_rd(8'h7F, r);
    chk(32'(r), 32'h1F, "five dots");
    u_host.instr(8'h04);
    u_host.instr(8'h40);
    u_host.data_wr(8'h11);
    u_host.xfer(OFS_INSTR, 1'b0, 8'h00, r);
    chk(32'(r), 32'h3F, "wrap down");
    u_host.instr(8'hE5);
    chk(32'({glyph_select, cursor_addr}), 32'h65, "dd addr");
  endtask

  task automatic t_busy();
    u_host.xfer(OFS_INSTR, 1'b1, 8'h08, r);
    t0 = $time;
    chk(32'(busy), 32'h1, "busy set");
    u_host.xfer(OFS_INSTR, 1'b1, 8'h0F, r);
    u_host.xfer(OFS_INSTR, 1'b0, 8'h00, r);
    chk(32'(r), 32'hE5, "status busy");
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(($time - t0) / PERIOD_NS), 32'(EXEC_CYCLES), "exec time");
    chk(32'(display_on), 32'h0, "refused");
    u_host.xfer(8'h0C, 1'b0, 8'h00, r);
    chk(32'(r), 32'h00, "unmapped");
  endtask

  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    fail_count = 0;
    n_tests = 0;
    cycles = 0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    chk(32'({hreadyout, hresp, busy, display_on, glyph_select, brightness}), 32'h40, "reset");
    u_host.instr(8'h38);
    t_entry();
    t_pan();
    t_display();
    t_shift();
    t_bright();
    t_glyph();
    t_busy();
    // Mid-run reset must clear counter and display state
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    chk(32'({busy, display_on, glyph_select, cursor_addr, display_shift}), 32'h0, "mid reset");
    u_host.instr(8'h38);
    u_host.instr(8'h0C);
    chk(32'({display_on, cursor_on}), 32'h2, "after reset");
    close_out();
  end
endmodule

// [verilog/cdcd_blink.sv]
`timescale 1ns/10ps
module cdcd_blink
  import cdcd_pkg::*;
#(
  parameter int HALF_CYCLES = BLINK_HALF_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic enable_i,
  output logic phase_o
);
  logic [23:0] count;
  logic [23:0] next_count;
  logic phase;
  logic next_phase;

  always_comb begin
    next_count = count + 24'h000001;
    next_phase = phase;
    if (!enable_i) begin
      next_count = 24'h000000;
      next_phase = 1'b0;
    end else if (count == 24'(HALF_CYCLES - 1)) begin
      next_count = 24'h000000;
      next_phase = !phase;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= 24'h000000;
      phase <= 1'b0;
    end else begin
      count <= next_count;
      phase <= next_phase;
    end
  end

  assign phase_o = phase;

  a_blink_toggle_time: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (enable_i && $past(enable_i) && phase != $past(phase)) |-> count == 24'h000000)
    else $error("blink phase toggled off schedule");
endmodule

// [verilog/cdcd_pkg.sv]
package cdcd_pkg;
  localparam int CLK_MHZ = 20;
  localparam int CLK_HZ = 20000000;
  localparam int EXEC_NS = 666;
  localparam int EXEC_CYCLES = (EXEC_NS * CLK_MHZ + 999) / 1000;
  localparam int BLINK_HZ = 1;
  localparam int BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);
  localparam logic [3:0] BUSY_LOAD = 4'(EXEC_CYCLES);
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;
  localparam logic [6:0] DD_LINE1_LAST = 7'h27;
  localparam logic [6:0] DD_LINE2_FIRST = 7'h40;
  localparam logic [6:0] DD_LINE2_LAST = 7'h67;
  localparam logic [6:0] DD_FIRST = 7'h00;
  localparam logic [5:0] PAN_LAST = 6'h27;
  localparam logic [5:0] GLYPH_LAST = 6'h3F;
  localparam logic RST_INC = 1'b1;
  localparam logic RST_SHIFT = 1'b0;
  localparam logic RST_BUS8 = 1'b1;
  localparam logic RST_DISP = 1'b0;
  localparam logic RST_CURSOR = 1'b0;
  localparam logic RST_BLINK = 1'b0;
  localparam logic [1:0] RST_BRIGHT = 2'h0;
  localparam logic [6:0] RST_AC = 7'h00;
  localparam logic [5:0] RST_PAN = 6'h00;
  localparam int ST_DISP = 0;
  localparam int ST_CURSOR = 1;
  localparam int ST_BLINK = 2;
  localparam int ST_INC = 3;
  localparam int ST_SHIFT = 4;
  localparam int ST_BUS8 = 5;
  localparam int ST_BRIGHT = 6;
  localparam int ST_GLYPH = 8;
  localparam int ST_PEND = 9;
  localparam int ST_NIB = 10;
  localparam int ST_PAN = 16;

  // Line-aware step; glyph space is a plain six-bit ring
  function automatic logic [6:0] cdcd_ac_step(input logic [6:0] ac, input logic glyph, input logic up);
    logic [6:0] res;
    res = up ? ac + 7'h01 : ac - 7'h01;
    if (glyph) begin
      res = {1'b0, res[5:0]};
    end else if (up && ac == DD_LINE1_LAST) begin
      res = DD_LINE2_FIRST;
    end else if (up && ac == DD_LINE2_LAST) begin
      res = DD_FIRST;
    end else if (!up && ac == DD_FIRST) begin
      res = DD_LINE2_LAST;
    end else if (!up && ac == DD_LINE2_FIRST) begin
      res = DD_LINE1_LAST;
    end
    return res;
  endfunction
endpackage

// [verilog/cdcd_ram.sv]
`timescale 1ns/10ps
module cdcd_ram
  import cdcd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic we_i,
  input wire logic glyph_sel_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] display_ram [0:127];
  logic [4:0] glyph_ram [0:63];

  always_ff @(posedge sys_clk_i) begin
    if (we_i && !glyph_sel_i) begin
      display_ram[addr_i] <= wdata_i;
    end
    if (we_i && glyph_sel_i) begin
      glyph_ram[addr_i[5:0]] <= wdata_i[4:0];
    end
  end

  assign rdata_o = glyph_sel_i ? {3'h0, glyph_ram[addr_i[5:0]]} : display_ram[addr_i];

  // glyph row stored five bits wide
  a_glyph_five_bits: assert property (@(posedge sys_clk_i) (we_i && glyph_sel_i)
    |=> glyph_ram[$past(addr_i[5:0])] == $past(wdata_i[4:0]))
    else $error("glyph row not stored in five bits");
endmodule

// [verilog/cdcd_top.sv]
`timescale 1ns/10ps
module cdcd_top
  import cdcd_pkg::*;
#(
  parameter int BLINK_HALF = BLINK_HALF_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  output logic display_on_o,
  output logic power_enable_o,
  output logic cursor_on_o,
  output logic cursor_all_dots_o,
  output logic [1:0] brightness_o,
  output logic [5:0] display_shift_o,
  output logic [6:0] cursor_addr_o,
  output logic glyph_select_o,
  output logic busy_o
);
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WAIT = 3'b010,
    BUS_DONE = 3'b100
  } cdcd_bus_type;

  localparam int BUSY_SPAN = EXEC_CYCLES;

  cdcd_bus_type bus_state;
  cdcd_bus_type next_bus_state;
  logic req_write;
  logic next_req_write;
  logic [7:0] req_ofs;
  logic [7:0] next_req_ofs;
  logic hready;
  logic next_hready;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic accept;
  logic [31:0] state_word;

  logic [6:0] ac;
  logic [6:0] next_ac;
  logic glyph_sel;
  logic next_glyph_sel;
  logic inc;
  logic next_inc;
  logic shift_en;
  logic next_shift_en;
  logic disp_on;
  logic next_disp_on;
  logic cursor_on;
  logic next_cursor_on;
  logic blink_on;
  logic next_blink_on;
  logic bus8;
  logic next_bus8;
  logic [1:0] bright;
  logic [1:0] next_bright;
  logic bright_pend;
  logic next_bright_pend;
  logic nib_pend;
  logic next_nib_pend;
  logic [3:0] nib_hi;
  logic [3:0] next_nib_hi;
  logic [5:0] pan;
  logic [5:0] next_pan;
  logic [3:0] busy_cnt;
  logic [3:0] next_busy_cnt;
  logic busy_flag;
  logic next_busy_flag;
  logic dots;
  logic next_dots;

  logic [7:0] cmd;
  logic byte_ok;
  logic exec_instr;
  logic exec_data;
  logic rd_go;
  logic exec_go;
  logic ram_we;
  logic [7:0] ram_rdata;
  logic blink_phase;

  // Panning ring over the forty columns of a line
  function automatic logic [5:0] cdcd_pan_step(input logic [5:0] cur, input logic left);
    logic [5:0] res;
    res = left ? cur + 6'h01 : cur - 6'h01;
    if (left && cur == PAN_LAST) begin
      res = 6'h00;
    end else if (!left && cur == 6'h00) begin
      res = PAN_LAST;
    end
    return res;
  endfunction

  assign accept = hsel_i && htrans_i[1] && hready_i;

  always_comb begin
    state_word = 32'h00000000;
    state_word[ST_DISP] = disp_on;
    state_word[ST_CURSOR] = cursor_on;
    state_word[ST_BLINK] = blink_on;
    state_word[ST_INC] = inc;
    state_word[ST_SHIFT] = shift_en;
    state_word[ST_BUS8] = bus8;
    state_word[ST_BRIGHT +: 2] = bright;
    state_word[ST_GLYPH] = glyph_sel;
    state_word[ST_PEND] = bright_pend;
    state_word[ST_NIB] = nib_pend;
    state_word[ST_PAN +: 6] = pan;
  end

  // One wait state gives time to fetch RAM and status
  always_comb begin
    next_bus_state = bus_state;
    next_req_write = req_write;
    next_req_ofs = req_ofs;
    next_rdata = rdata;
    unique case (bus_state)
      BUS_IDLE, BUS_DONE: begin
        next_bus_state = BUS_IDLE;
        if (accept) begin
          next_bus_state = BUS_WAIT;
          next_req_write = hwrite_i;
          next_req_ofs = haddr_i[7:0];
        end
      end
      BUS_WAIT: begin
        next_bus_state = BUS_DONE;
        next_rdata = 32'h00000000;
        if (!req_write) begin
          unique case (req_ofs)
            OFS_INSTR: next_rdata = {24'h000000, busy_flag, ac};
            OFS_DATA: next_rdata = {24'h000000, ram_rdata};
            OFS_STATE: next_rdata = state_word;
            default: next_rdata = 32'h00000000;
          endcase
        end
      end
      default: next_bus_state = BUS_IDLE;
    endcase
    next_hready = next_bus_state != BUS_WAIT;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_state <= BUS_IDLE;
      req_write <= 1'b0;
      req_ofs <= 8'h00;
      hready <= 1'b1;
      rdata <= 32'h00000000;
    end else begin
      bus_state <= next_bus_state;
      req_write <= next_req_write;
      req_ofs <= next_req_ofs;
      hready <= next_hready;
      rdata <= next_rdata;
    end
  end

  always_comb begin
    next_ac = ac;
    next_glyph_sel = glyph_sel;
    next_inc = inc;
    next_shift_en = shift_en;
    next_disp_on = disp_on;
    next_cursor_on = cursor_on;
    next_blink_on = blink_on;
    next_bus8 = bus8;
    next_bright = bright;
    next_bright_pend = bright_pend;
    next_nib_pend = nib_pend;
    next_nib_hi = nib_hi;
    next_pan = pan;
    cmd = hwdata_i[7:0];
    byte_ok = 1'b0;
    ram_we = 1'b0;
    // Writes while busy are dropped; host must poll first
    if (bus_state == BUS_WAIT && req_write && !busy_flag && (req_ofs == OFS_INSTR || req_ofs == OFS_DATA)) begin
      if (bus8) begin
        byte_ok = 1'b1;
      end else if (!nib_pend) begin
        next_nib_pend = 1'b1;
        next_nib_hi = hwdata_i[7:4];
      end else begin
        byte_ok = 1'b1;
        next_nib_pend = 1'b0;
        cmd = {nib_hi, hwdata_i[7:4]};
      end
    end
    exec_instr = byte_ok && req_ofs == OFS_INSTR;
    exec_data = byte_ok && req_ofs == OFS_DATA;
    rd_go = bus_state == BUS_WAIT && !req_write && req_ofs == OFS_DATA && !busy_flag;
    if (exec_instr) begin
      next_bright_pend = 1'b0;
      if (cmd[7]) begin
        next_ac = cmd[6:0];
        next_glyph_sel = 1'b0;
      end else if (cmd[6]) begin
        next_ac = {1'b0, cmd[5:0]};
        next_glyph_sel = 1'b1;
      end else if (cmd[5]) begin
        next_bus8 = cmd[4];
        next_bright_pend = 1'b1;
      end else if (cmd[4]) begin
        if (cmd[3]) begin
          next_pan = cdcd_pan_step(pan, !cmd[2]);
        end else begin
          next_ac = cdcd_ac_step(ac, glyph_sel, cmd[2]);
        end
      end else if (cmd[3]) begin
        next_disp_on = cmd[2];
        next_cursor_on = cmd[1];
        next_blink_on = cmd[0];
      end else if (cmd[2]) begin
        next_inc = cmd[1];
        next_shift_en = cmd[0];
      end
    end
    if (exec_data) begin
      if (bright_pend) begin
        next_bright = cmd[1:0];
        next_bright_pend = 1'b0;
      end else begin
        ram_we = 1'b1;
        next_ac = cdcd_ac_step(ac, glyph_sel, inc);
        if (shift_en && !glyph_sel) begin
          next_pan = cdcd_pan_step(pan, inc);
        end
      end
    end
    if (rd_go) begin
      next_ac = cdcd_ac_step(ac, glyph_sel, inc);
    end
    exec_go = exec_instr || exec_data || rd_go;
    next_busy_cnt = busy_cnt;
    if (exec_go) begin
      next_busy_cnt = BUSY_LOAD;
    end else if (busy_cnt != 4'h0) begin
      next_busy_cnt = busy_cnt - 4'h1;
    end
    next_busy_flag = next_busy_cnt != 4'h0;
    next_dots = blink_on && disp_on && blink_phase;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ac <= RST_AC;
      glyph_sel <= 1'b0;
      inc <= RST_INC;
      shift_en <= RST_SHIFT;
      disp_on <= RST_DISP;
      cursor_on <= RST_CURSOR;
      blink_on <= RST_BLINK;
      bus8 <= RST_BUS8;
      bright <= RST_BRIGHT;
      bright_pend <= 1'b0;
      nib_pend <= 1'b0;
      nib_hi <= 4'h0;
      pan <= RST_PAN;
      busy_cnt <= 4'h0;
      busy_flag <= 1'b0;
      dots <= 1'b0;
    end else begin
      ac <= next_ac;
      glyph_sel <= next_glyph_sel;
      inc <= next_inc;
      shift_en <= next_shift_en;
      disp_on <= next_disp_on;
      cursor_on <= next_cursor_on;
      blink_on <= next_blink_on;
      bus8 <= next_bus8;
      bright <= next_bright;
      bright_pend <= next_bright_pend;
      nib_pend <= next_nib_pend;
      nib_hi <= next_nib_hi;
      pan <= next_pan;
      busy_cnt <= next_busy_cnt;
      busy_flag <= next_busy_flag;
      dots <= next_dots;
    end
  end

  cdcd_ram u_ram (
    .sys_clk_i(sys_clk_i),
    .we_i(ram_we),
    .glyph_sel_i(glyph_sel),
    .addr_i(ac),
    .wdata_i(cmd),
    .rdata_o(ram_rdata)
  );

  cdcd_blink #(
    .HALF_CYCLES(BLINK_HALF)
  ) u_blink (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .enable_i(blink_on),
    .phase_o(blink_phase)
  );

  assign hreadyout_o = hready;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata;
  assign display_on_o = disp_on;
  assign power_enable_o = disp_on;
  assign cursor_on_o = cursor_on;
  assign cursor_all_dots_o = dots;
  assign brightness_o = bright;
  assign display_shift_o = pan;
  assign cursor_addr_o = ac;
  assign glyph_select_o = glyph_sel;
  assign busy_o = busy_flag;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_wait_answer;
    !hreadyout_o ##1 hreadyout_o;
  endsequence

  sequence s_busy_run;
    busy_o ##[BUSY_SPAN:BUSY_SPAN] !busy_o;
  endsequence

  a_bus_wait_state: assert property (accept |=> s_wait_answer)
    else $error("bus answer not after one wait state");

  a_busy_span_len: assert property (exec_go |=> s_busy_run)
    else $error("busy flag length wrong");

  a_glyph_step_wrap: assert property (exec_data && !bright_pend && glyph_sel && inc
    |=> ac == {1'b0, 6'($past(ac[5:0]) + 6'h01)})
    else $error("glyph counter did not step or wrap");

  a_pan_opposite: assert property (exec_data && !bright_pend && !glyph_sel && shift_en
    |=> display_shift_o == cdcd_pan_step($past(pan), $past(inc)))
    else $error("display pan not opposite to counter");

  a_read_no_pan: assert property (rd_go |=> $stable(display_shift_o))
    else $error("data read shifted display");

  a_bright_taken: assert property (exec_data && bright_pend
    |=> brightness_o == $past(cmd[1:0]) && $stable(ac) && !bright_pend)
    else $error("brightness byte not taken");

  a_bright_cancel: assert property (exec_instr && cmd[7:5] != 3'b001 |=> !bright_pend)
    else $error("instruction left brightness pending");

  a_disp_ctrl: assert property (exec_instr && cmd[7:3] == 5'h01
    |=> display_on_o == $past(cmd[2]) && power_enable_o == $past(cmd[2]) && cursor_on_o == $past(cmd[1]))
    else $error("display control not applied");

  a_status_word: assert property (bus_state == BUS_WAIT && !req_write && req_ofs == OFS_INSTR
    |=> hrdata_o[7:0] == {$past(busy_flag), $past(ac)})
    else $error("status read wrong");

  a_busy_drop: assert property (busy_o && bus_state == BUS_WAIT && req_write |=> $stable(ac) && $stable(pan))
    else $error("write accepted while busy");
endmodule
